// File: design/bdsc_pkg.sv
// Package for the bias converter source control block: map, fields, types.
// Assumes a byte-wide register port on mclk driven by the serial host front end.

package bdsc_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 9;

    localparam logic [8:0] ADDR_CTRL0  = 9'h080;
    localparam logic [8:0] ADDR_T1ROW  = 9'h081;
    localparam logic [8:0] ADDR_T2ROW  = 9'h082;
    localparam logic [8:0] ADDR_DIR1   = 9'h083;
    localparam logic [8:0] ADDR_DIR2   = 9'h084;
    localparam logic [8:0] ADDR_SRC    = 9'h085;
    localparam logic [8:0] ADDR_WGATE  = 9'h086;
    localparam logic [8:0] ADDR_STAT   = 9'h087;
    localparam logic [8:0] T1_BASE     = 9'h090;
    localparam logic [8:0] T2_BASE     = 9'h0d0;
    localparam logic [8:0] TBL_END     = 9'h110;

    // ------------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------------
    localparam int unsigned SRC_C2OV   = 7;
    localparam int unsigned SRC_T2OV   = 6;
    localparam int unsigned SRC_C1OV   = 5;
    localparam int unsigned SRC_T1OV   = 4;
    localparam int unsigned SRC_FS2_LO = 2;
    localparam int unsigned SRC_FS1_LO = 0;
    localparam int unsigned C0_POL1    = 0;
    localparam int unsigned C0_POL2    = 1;
    localparam int unsigned C0_REF     = 2;
    localparam int unsigned C0_ADC_INPUT_SEL   = 3;
    localparam int unsigned C0_FILT    = 4;
    localparam int unsigned WGATE_BIT  = 7;
    localparam int unsigned STAT_LO    = 2;

    localparam logic [7:0] WGATE_SET   = 8'h80;
    localparam logic [7:0] WGATE_CLR   = 8'h00;
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [5:0] CODE_RST    = 6'h00;
    localparam int unsigned FILT_MATCHES = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FS_EXT  = 2'b00,
        FS_LOW  = 2'b01,
        FS_MID  = 2'b10,
        FS_HIGH = 2'b11
    } bdsc_fs_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [8:0] addr;
        logic [7:0] data;
    } bdsc_req_t;

    typedef struct packed {
        logic       ack;
        logic       nak;
        logic       rvalid;
        logic [7:0] rdata;
    } bdsc_rsp_t;

endpackage

// File: design/bdsc_adc_filter.sv
// Stability filter for the temperature converter result.
// Assumes conversion results arrive as one-cycle strobes on mclk.
`timescale 1ns/1ps

module bdsc_adc_filter #(
    parameter int unsigned CODE_W  = 6,
    parameter int unsigned MATCHES = bdsc_pkg::FILT_MATCHES
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              conv_valid,
    input  wire logic [CODE_W-1:0] conv_code,
    input  wire logic              bypass,
    output logic      [CODE_W-1:0] code_q
);

    localparam int unsigned RUN_W = $clog2(MATCHES);
    localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(MATCHES - 1);

    logic [CODE_W-1:0] last_q;
    logic [RUN_W-1:0]  run_q;
    logic [RUN_W-1:0]  run_d;
    logic              seen_q;
    wire               same = seen_q && (conv_code == last_q);
    wire               take;

    // A differing result restarts the run count at zero.
    assign run_d = !same ? '0 : (run_q == RUN_MAX) ? RUN_MAX
                 : RUN_W'(run_q + 1'b1);
    assign take  = conv_valid && (bypass || run_d == RUN_MAX);

    always_ff @(posedge mclk) begin
        if (rst) begin
            last_q <= '0;
            run_q  <= '0;
            seen_q <= 1'b0;
            code_q <= '0;
        end else if (conv_valid) begin
            last_q <= conv_code;
            run_q  <= run_d;
            seen_q <= 1'b1;
            if (take) begin
                code_q <= conv_code;
            end
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_filter_bypass:
    assert property (conv_valid && bypass |=> code_q == $past(conv_code))
        else $error("bypassed filter did not pass the conversion");

    a_filter_restart:
    assert property (conv_valid && !bypass && conv_code != code_q && !same
                     |=> $stable(code_q))
        else $error("filter updated on a fresh result");

    c_filter_update:
    cover property (conv_valid && !bypass ##1 $changed(code_q));

endmodule

// File: design/bdsc_ctrl.sv
// Control logic for two table-driven current converters: registers,
// write gate, table storage, row selection and converter input selection.
// Assumes a byte register port on mclk from the serial host front end, and
// converter result strobes produced by logic on the same clock.
`timescale 1ns/1ps

module bdsc_ctrl (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire bdsc_pkg::bdsc_req_t req,
    output bdsc_pkg::bdsc_rsp_t      rsp_q,
    input  wire logic                conv_valid,
    input  wire logic [5:0]          conv_code,
    output bdsc_pkg::bdsc_fs_t       gen1_fullscale_sel,
    output bdsc_pkg::bdsc_fs_t       gen2_fullscale_sel,
    output logic                     gen1_polarity_sel,
    output logic                     gen2_polarity_sel,
    output logic                     reference_source_sel,
    output logic                     ref_pin_drive_q,
    output logic                     adc_input_sel,
    output logic [7:0]               dac1_code_q,
    output logic [7:0]               dac2_code_q,
    output logic [8:0]               t1_row_addr_q,
    output logic [8:0]               t2_row_addr_q
);

    // ------------------------------------------------------------------
    // Registers and table storage
    // ------------------------------------------------------------------
    logic [7:0] ctrl0_q;
    logic [5:0] table1_row_value;
    logic [5:0] table2_row_value;
    logic [7:0] dir1_q;
    logic [7:0] dir2_q;
    logic [7:0] src_q;
    logic       write_gate_latch;
    logic [5:0] adc_code;
    logic [7:0] tbl_mem [0:127];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire is_ctrl0 = req.addr == bdsc_pkg::ADDR_CTRL0;
    wire is_t1row = req.addr == bdsc_pkg::ADDR_T1ROW;
    wire is_t2row = req.addr == bdsc_pkg::ADDR_T2ROW;
    wire is_dir1  = req.addr == bdsc_pkg::ADDR_DIR1;
    wire is_dir2  = req.addr == bdsc_pkg::ADDR_DIR2;
    wire is_src   = req.addr == bdsc_pkg::ADDR_SRC;
    wire is_wgate = req.addr == bdsc_pkg::ADDR_WGATE;
    wire is_stat  = req.addr == bdsc_pkg::ADDR_STAT;
    wire is_tbl   = req.addr >= bdsc_pkg::T1_BASE
                 && req.addr < bdsc_pkg::TBL_END;
    wire [8:0] tbl_off = req.addr - bdsc_pkg::T1_BASE;
    wire [6:0] tbl_idx = tbl_off[6:0];

    wire is_ctl   = is_ctrl0 | is_t1row | is_t2row
                  | is_dir1 | is_dir2 | is_src;

    // The gate register itself is always writable, otherwise the latch
    // could never be opened. The status register and unmapped bytes
    // refuse every write.
    wire wr_open  = write_gate_latch && (is_ctl || is_tbl);
    wire wr_acc   = req.wr && (is_wgate || wr_open);
    wire wr_ok    = req.wr && wr_open;
    wire wr_rej   = req.wr && !wr_acc;

    wire gate_set = req.wr && is_wgate && req.data == bdsc_pkg::WGATE_SET;
    wire gate_clr = req.wr && is_wgate && req.data == bdsc_pkg::WGATE_CLR;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [7:0] wgate_rd = {write_gate_latch, 7'h00};
    wire [7:0] stat_rd  = {adc_code, 2'b00};
    wire [7:0] rd_mux =
          is_ctrl0 ? ctrl0_q
        : is_t1row ? {2'b00, table1_row_value}
        : is_t2row ? {2'b00, table2_row_value}
        : is_dir1  ? dir1_q
        : is_dir2  ? dir2_q
        : is_src   ? src_q
        : is_wgate ? wgate_rd
        : is_stat  ? stat_rd
        : is_tbl   ? tbl_mem[tbl_idx]
        : 8'h00;

    bdsc_pkg::bdsc_rsp_t rsp_d;
    assign rsp_d.ack    = wr_acc;
    assign rsp_d.nak    = wr_rej;
    assign rsp_d.rvalid = req.rd && !req.wr;
    assign rsp_d.rdata  = (req.rd && !req.wr) ? rd_mux : 8'h00;

    always_ff @(posedge mclk) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // ------------------------------------------------------------------
    // Control register writes
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl0_q          <= bdsc_pkg::REG_RST;
            table1_row_value <= bdsc_pkg::CODE_RST;
            table2_row_value <= bdsc_pkg::CODE_RST;
            dir1_q           <= bdsc_pkg::REG_RST;
            dir2_q           <= bdsc_pkg::REG_RST;
            src_q            <= bdsc_pkg::REG_RST;
        end else if (wr_ok) begin
            if (is_ctrl0) begin
                ctrl0_q <= req.data;
            end
            if (is_t1row) begin
                table1_row_value <= req.data[5:0];
            end
            if (is_t2row) begin
                table2_row_value <= req.data[5:0];
            end
            if (is_dir1) begin
                dir1_q <= req.data;
            end
            if (is_dir2) begin
                dir2_q <= req.data;
            end
            if (is_src) begin
                src_q <= req.data;
            end
        end
    end

    // Only the exact set and clear patterns move the latch; other bytes
    // are acknowledged and dropped, and the reserved bits hold no state.
    always_ff @(posedge mclk) begin
        if (rst) begin
            write_gate_latch <= 1'b0;
        end else if (gate_set) begin
            write_gate_latch <= 1'b1;
        end else if (gate_clr) begin
            write_gate_latch <= 1'b0;
        end
    end

    // Table bytes hold no reset value; they stand for nonvolatile storage
    // whose programming cycle lives outside this block.
    always_ff @(posedge mclk) begin
        if (wr_ok && is_tbl) begin
            tbl_mem[tbl_idx] <= req.data;
        end
    end

    // ------------------------------------------------------------------
    // Analog selects
    // ------------------------------------------------------------------
    assign gen1_fullscale_sel =
        bdsc_pkg::bdsc_fs_t'(src_q[bdsc_pkg::SRC_FS1_LO +: 2]);
    assign gen2_fullscale_sel =
        bdsc_pkg::bdsc_fs_t'(src_q[bdsc_pkg::SRC_FS2_LO +: 2]);
    assign gen1_polarity_sel    = ctrl0_q[bdsc_pkg::C0_POL1];
    assign gen2_polarity_sel    = ctrl0_q[bdsc_pkg::C0_POL2];
    assign reference_source_sel = ctrl0_q[bdsc_pkg::C0_REF];
    assign adc_input_sel        = ctrl0_q[bdsc_pkg::C0_ADC_INPUT_SEL];

    always_ff @(posedge mclk) begin
        if (rst) begin
            ref_pin_drive_q <= 1'b1;
        end else begin
            ref_pin_drive_q <= !ctrl0_q[bdsc_pkg::C0_REF];
        end
    end

    // ------------------------------------------------------------------
    // Converter result filter
    // ------------------------------------------------------------------
    bdsc_adc_filter #(
        .CODE_W  (6),
        .MATCHES (bdsc_pkg::FILT_MATCHES)
    ) u_filter (
        .mclk       (mclk),
        .rst        (rst),
        .conv_valid (conv_valid),
        .conv_code  (conv_code),
        .bypass     (ctrl0_q[bdsc_pkg::C0_FILT]),
        .code_q     (adc_code)
    );

    // ------------------------------------------------------------------
    // Row and converter input selection
    // ------------------------------------------------------------------
    wire t1_ov = src_q[bdsc_pkg::SRC_T1OV];
    wire c1_ov = src_q[bdsc_pkg::SRC_C1OV];
    wire t2_ov = src_q[bdsc_pkg::SRC_T2OV];
    wire c2_ov = src_q[bdsc_pkg::SRC_C2OV];

    wire [5:0] row1 = t1_ov ? table1_row_value : adc_code;
    wire [5:0] row2 = t2_ov ? table2_row_value : adc_code;
    wire [8:0] addr1 = bdsc_pkg::T1_BASE + {3'b000, row1};
    wire [8:0] addr2 = bdsc_pkg::T2_BASE + {3'b000, row2};
    wire [7:0] lookup_table_one = tbl_mem[{1'b0, row1}];
    wire [7:0] lookup_table_two = tbl_mem[{1'b1, row2}];

    // The direct byte wins regardless of the row override.
    wire [7:0] dac1_d = c1_ov ? dir1_q : lookup_table_one;
    wire [7:0] dac2_d = c2_ov ? dir2_q : lookup_table_two;

    always_ff @(posedge mclk) begin
        if (rst) begin
            dac1_code_q   <= bdsc_pkg::REG_RST;
            dac2_code_q   <= bdsc_pkg::REG_RST;
            t1_row_addr_q <= bdsc_pkg::T1_BASE;
            t2_row_addr_q <= bdsc_pkg::T2_BASE;
        end else begin
            dac1_code_q   <= dac1_d;
            dac2_code_q   <= dac2_d;
            t1_row_addr_q <= addr1;
            t2_row_addr_q <= addr2;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_nak_locked:
    assert property (req.wr && !write_gate_latch && !is_wgate
                     |=> rsp_q.nak && !rsp_q.ack)
        else $error("write taken while the gate was closed");

    a_locked_src_hold:
    assert property (req.wr && !write_gate_latch && is_src |=> $stable(src_q))
        else $error("source select changed while the gate was closed");

    a_gate_set:
    assert property (gate_set |=> write_gate_latch && rsp_q.ack)
        else $error("gate did not open on the set pattern");

    a_gate_clear:
    assert property (gate_clr |=> !write_gate_latch)
        else $error("gate did not close on the clear pattern");

    a_gate_hold:
    assert property (write_gate_latch && !gate_clr |=> write_gate_latch)
        else $error("gate dropped without a clear write");

    a_gate_read:
    assert property (req.rd && !req.wr && is_wgate
                     |=> rsp_q.rvalid && rsp_q.rdata == {$past(write_gate_latch), 7'h00})
        else $error("gate register read back wrong");

    a_status_read:
    assert property (req.rd && !req.wr && is_stat
                     |=> rsp_q.rdata == {$past(adc_code), 2'b00})
        else $error("status register read back wrong");

    a_dac1_direct:
    assert property (c1_ov |=> dac1_code_q == $past(dir1_q))
        else $error("channel one ignored its direct byte");

    a_row1_adc:
    assert property (!t1_ov |=> t1_row_addr_q == 9'h090 + {3'b000, $past(adc_code)})
        else $error("table one row not taken from the converter");

    a_row2_override:
    assert property (t2_ov |=> t2_row_addr_q == 9'h0d0 + {3'b000, $past(table2_row_value)})
        else $error("table two row override ignored");

    c_gate_then_write:
    cover property (gate_set ##[1:4] (req.wr && is_tbl));

    c_direct_dac2:
    cover property (c2_ov && t2_ov);

    c_locked_nak:
    cover property (rsp_q.nak);

endmodule

// File: tb/bdsc_host_model.sv
// Behavioural model of the serial host front end that issues byte requests.
// Assumes the block takes a request at a rising mclk edge and answers one edge later.
`timescale 1ns/1ps

module bdsc_host_model (
    input  wire logic                mclk,
    output bdsc_pkg::bdsc_req_t      req,
    input  wire bdsc_pkg::bdsc_rsp_t rsp
);
    initial begin
        req = '0;
    end

    // ------------------------------------------------------------------
    // Single byte transfer
    // ------------------------------------------------------------------
    // The strobe stands for exactly one taking edge and is dropped at the next
    // falling edge, so two transfers are always at least one idle cycle apart.
    task automatic xfer(input  logic                w,
                        input  logic [8:0]          a,
                        input  logic [7:0]          d,
                        output bdsc_pkg::bdsc_rsp_t r);
        @(negedge mclk);
        req.wr   = w;
        req.rd   = !w;
        req.addr = a;
        req.data = d;
        @(negedge mclk);
        r        = rsp;
        req      = '0;
    endtask
endmodule

// File: tb/bdsc_ctrl_bench.sv
// Self-checking bench for the converter source control block.
// Assumes the host model answers transfers and the bench drives conversion strobes.
`timescale 1ns/1ps

module bdsc_ctrl_bench;
    logic                mclk;
    logic                rst;
    logic                conv_valid;
    logic [5:0]          conv_code;
    bdsc_pkg::bdsc_req_t req;
    bdsc_pkg::bdsc_rsp_t rsp_q;
    bdsc_pkg::bdsc_fs_t  fs1;
    bdsc_pkg::bdsc_fs_t  fs2;
    logic                pol1;
    logic                pol2;
    logic                ref_sel;
    logic                ref_drv;
    logic                adc_sel;
    logic [7:0]          dac1;
    logic [7:0]          dac2;
    logic [8:0]          row1;
    logic [8:0]          row2;
    int                  failures;
    int                  cmp_count;

    bdsc_ctrl i_bdsc_ctrl (.mclk(mclk), .rst(rst), .req(req), .rsp_q(rsp_q),
        .conv_valid(conv_valid), .conv_code(conv_code), .gen1_fullscale_sel(fs1),
        .gen2_fullscale_sel(fs2), .gen1_polarity_sel(pol1), .gen2_polarity_sel(pol2),
        .reference_source_sel(ref_sel), .ref_pin_drive_q(ref_drv),
        .adc_input_sel(adc_sel), .dac1_code_q(dac1), .dac2_code_q(dac2),
        .t1_row_addr_q(row1), .t2_row_addr_q(row2));

    bdsc_host_model i_bdsc_host_model (.mclk(mclk), .req(req), .rsp(rsp_q));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic ok);
        bdsc_pkg::bdsc_rsp_t r;
        i_bdsc_host_model.xfer(1'b1, a, d, r);
        check({r.ack, r.nak}, {ok, !ok});
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        bdsc_pkg::bdsc_rsp_t r;
        i_bdsc_host_model.xfer(1'b0, a, 8'h00, r);
        check({r.rvalid, r.rdata}, {1'b1, exp});
    endtask

    // A stale code is inverted once the strobe drops, so nothing latches it late.
    task automatic conv(input logic [5:0] c);
        @(negedge mclk);
        conv_valid = 1'b1;
        conv_code  = c;
        @(negedge mclk);
        conv_valid = 1'b0;
        conv_code  = ~c;
    endtask

    task automatic settle();
        repeat (2) @(negedge mclk);
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, reset and watchdog
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        close_out();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        failures   = 0;
        cmp_count  = 0;
        rst        = 1'b1;
        conv_valid = 1'b0;
        conv_code  = 6'h00;
        repeat (10) @(negedge mclk);
        rst = 1'b0;
        check({fs1, fs2, pol1, pol2, ref_sel, ref_drv, adc_sel}, 32'h0002);
        check({row1, 7'h00}, {bdsc_pkg::T1_BASE, 7'h00});
        check({row2, 7'h00}, {bdsc_pkg::T2_BASE, 7'h00});
        for (int a = 16'h80; a < 16'h89; a++) begin
            rd(9'(a), 8'h00);
        end
        wr(bdsc_pkg::ADDR_SRC, 8'h0f, 1'b0);
        rd(bdsc_pkg::ADDR_SRC, 8'h00);
        wr(bdsc_pkg::ADDR_WGATE, 8'h80, 1'b1);
        rd(bdsc_pkg::ADDR_WGATE, 8'h80);
        wr(bdsc_pkg::ADDR_WGATE, 8'h7f, 1'b1);
        rd(bdsc_pkg::ADDR_WGATE, 8'h80);
        wr(bdsc_pkg::ADDR_STAT, 8'hff, 1'b0);
        for (int i = 0; i < 4; i++) begin
            wr(bdsc_pkg::ADDR_SRC, {4'h0, 2'(3 - i), 2'(i)}, 1'b1);
            check(fs1, 32'(i));
            check(fs2, 32'(3 - i));
        end
        wr(bdsc_pkg::ADDR_CTRL0, 8'h01, 1'b1);
        check({fs1, pol1, pol2}, 32'h0e);
        wr(bdsc_pkg::ADDR_CTRL0, 8'h0e, 1'b1);
        settle();
        check({pol1, pol2, ref_sel, ref_drv, adc_sel}, 32'h0d);
        wr(bdsc_pkg::ADDR_CTRL0, 8'h00, 1'b1);
        settle();
        check({ref_drv, adc_sel}, 32'h2);
        wr(bdsc_pkg::ADDR_SRC, 8'h00, 1'b1);
        wr(bdsc_pkg::T1_BASE + 9'h005, 8'h5a, 1'b1);
        wr(bdsc_pkg::T2_BASE + 9'h005, 8'ha5, 1'b1);
        wr(bdsc_pkg::T1_BASE + 9'h03f, 8'h11, 1'b1);
        wr(bdsc_pkg::T2_BASE + 9'h001, 8'h22, 1'b1);
        repeat (4) conv(6'h05);
        settle();
        rd(bdsc_pkg::ADDR_STAT, 8'h14);
        check({row1, row2}, {9'h095, 9'h0d5});
        check({dac1, dac2}, 32'h5aa5);
        repeat (3) conv(6'h07);
        conv(6'h03);
        rd(bdsc_pkg::ADDR_STAT, 8'h14);
        repeat (3) conv(6'h03);
        rd(bdsc_pkg::ADDR_STAT, 8'h0c);
        wr(bdsc_pkg::ADDR_T1ROW, 8'h3f, 1'b1);
        wr(bdsc_pkg::ADDR_T2ROW, 8'h01, 1'b1);
        wr(bdsc_pkg::ADDR_SRC, 8'h50, 1'b1);
        settle();
        check({row1, row2}, {9'h0cf, 9'h0d1});
        check({dac1, dac2}, 32'h1122);
        wr(bdsc_pkg::ADDR_DIR1, 8'h3c, 1'b1);
        wr(bdsc_pkg::ADDR_DIR2, 8'hc3, 1'b1);
        wr(bdsc_pkg::ADDR_SRC, 8'hf0, 1'b1);
        settle();
        check({dac1, dac2}, 32'h3cc3);
        wr(bdsc_pkg::ADDR_SRC, 8'ha0, 1'b1);
        wr(bdsc_pkg::ADDR_DIR2, 8'h99, 1'b1);
        settle();
        check({dac1, dac2}, 32'h3c99);
        wr(bdsc_pkg::ADDR_CTRL0, 8'h10, 1'b1);
        conv(6'h09);
        rd(bdsc_pkg::ADDR_STAT, 8'h24);
        wr(bdsc_pkg::ADDR_WGATE, 8'h00, 1'b1);
        rd(bdsc_pkg::ADDR_WGATE, 8'h00);
        wr(bdsc_pkg::ADDR_DIR1, 8'h00, 1'b0);
        rd(bdsc_pkg::ADDR_DIR1, 8'h3c);
        close_out();
    end
endmodule
